// ### rtl/dlc_pkg.sv
package dlc_pkg;

  // Width of the gray-coded delay code.
  localparam int DLC_CODE_W = 6;
  // Reset value of the binary delay code.
  localparam logic [5:0] DLC_CODE_RST = 6'h00;
  // Secondary clock divide settings.
  localparam logic [1:0] DLC_DIV_NONE = 2'h0;
  localparam logic [1:0] DLC_DIV_BY2 = 2'h1;
  localparam logic [1:0] DLC_DIV_BY4 = 2'h2;
  // Consecutive cycles the update enable must be seen high.
  localparam int DLC_UPD_HOLD = 2;
  // Matching phase samples needed before lock is declared.
  localparam int DLC_LOCK_CNT = 4;

  // Lock state machine.
  typedef enum logic [2:0]
  {
    DLC_ST_RESET = 3'b001,
    DLC_ST_TRACK = 3'b010,
    DLC_ST_LOCKED = 3'b100
  } dlc_state_t;

  // Configuration group from the fabric.
  typedef struct packed
  {
    logic follow_mode;
    logic [1:0] div_sel;
    logic [5:0] fine_shift;
  } dlc_cfg_t;

  // Inter-loop cascade group.
  typedef struct packed
  {
    logic inc;
    logic [5:0] code;
  } dlc_cascade_t;

endpackage

// ### rtl/dlc_port.sv
`timescale 1ns/1ps
// Functional notes
// - While the low-active loop reset is held low the loop state is reset synchronously; high releases it.
// - While the freeze input is high and follow mode is off, the delay arithmetic holds the present delay code unchanged.
// - The secondary clock is the reference clock shifted by a fine delay, optionally divided by 2 or 4.
// - The lock indicator is high while the feedback clock is aligned to the reference, low otherwise.
// - The applied delay setting is presented as a 6-bit gray-coded bus for other loops.
// - In follow mode the delay setting is taken from the gray-coded bus of another loop.
// - The difference flag is high whenever the computed value differs from the applied setting.
// - An increment indicator shows adjustment direction; in follow mode the incoming one is used.
// - The primary clock output carries the main loop clock derived from the reference clock.
module dlc_port #(
  parameter int CODE_W = 6,
  parameter int LOCK_CNT = 4
) (
  input wire logic clk,                          // Loop clock, 125 MHz.
  input wire logic rst,                          // Device reset, synchronous, active high.
  input wire logic reference_clock_in,           // Reference clock, sampled as a level.
  input wire logic feedback_clock_in,            // Feedback clock, sampled as a level.
  input wire logic sync_reset_low,               // Loop reset, active low.
  input wire logic arith_freeze,                 // Freezes the delay arithmetic.
  input wire logic delay_update_enable,          // Update request, held two cycles.
  input wire dlc_pkg::dlc_cfg_t cfg,             // Mode, divide and fine shift.
  input wire dlc_pkg::dlc_cascade_t cascade_in,  // Increment and gray code from another loop.
  output logic primary_clock_out,                // Main output clock.
  output logic secondary_clock_out,              // Shifted and divided clock.
  output logic lock,                             // Phase lock indicator.
  output logic update_needed_flag,               // Computed and applied settings differ.
  output dlc_pkg::dlc_cascade_t cascade_out      // Increment and gray code to other loops.
);
  import dlc_pkg::*;

  // Binary to gray conversion.
  function automatic logic [5:0] to_gray(input logic [5:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  // Gray to binary conversion.
  function automatic logic [5:0] to_bin(input logic [5:0] g);
    logic [5:0] b;
    b = '0;
    b[5] = g[5];
    for (int i = 4; i >= 0; i--)
    begin
      b[i] = b[i + 1] ^ g[i];
    end
    to_bin = b;
  endfunction

  logic loop_rst;
  logic ref_d;
  logic fb_d;
  logic ref_rise;
  logic fb_rise;
  logic fb_seen;
  logic [5:0] delay_control_value;
  logic [5:0] applied;
  logic [5:0] next_delay_control_value;
  logic next_inc;
  logic [1:0] upd_cnt;
  logic upd_ok;
  logic [2:0] match_cnt;
  dlc_state_t state;
  dlc_state_t next_state;
  logic [5:0] shift_line;
  logic [1:0] div_cnt;
  logic inc_dir;

  // loop reset
  // Either reset source clears the loop state in step with the clock.
  assign loop_rst = rst | ~sync_reset_low;

  // Edge history of both clocks, used for phase comparison.
  // It keeps sampling through reset, so a clock that is already high at release
  // does not show a false rising edge and step the arithmetic by mistake.
  always_ff @(posedge clk)
  begin
    ref_d <= reference_clock_in;
    fb_d <= feedback_clock_in;
  end

  assign ref_rise = reference_clock_in & ~ref_d;
  assign fb_rise = feedback_clock_in & ~fb_d;

  // Remember a feedback edge seen before the reference edge (feedback early).
  always_ff @(posedge clk)
  begin
    if (loop_rst || ref_rise)
    begin
      fb_seen <= 1'b0;
    end
    else if (fb_rise)
    begin
      fb_seen <= 1'b1;
    end
  end

  // Computed value: step toward alignment, or follow the other loop.
  always_comb
  begin
    next_delay_control_value = delay_control_value;
    next_inc = inc_dir;
    if (cfg.follow_mode)
    begin
      next_delay_control_value = to_bin(cascade_in.code);
      next_inc = cascade_in.inc;
    end
    else if (!arith_freeze && ref_rise && !fb_rise)
    begin
      // adjust direction
      // Feedback arrived early means more delay; late means less.
      if (fb_seen)
      begin
        next_delay_control_value = delay_control_value + 6'h01;
        next_inc = 1'b1;
      end
      else
      begin
        next_delay_control_value = delay_control_value - 6'h01;
        next_inc = 1'b0;
      end
    end
  end

  // Arithmetic register and direction flag.
  always_ff @(posedge clk)
  begin
    if (loop_rst)
    begin
      delay_control_value <= DLC_CODE_RST;
      inc_dir <= 1'b0;
    end
    else
    begin
      delay_control_value <= next_delay_control_value;
      inc_dir <= next_inc;
    end
  end

  // update qualification
  // A single-cycle glitch on the enable is ignored; two cycles are needed.
  always_ff @(posedge clk)
  begin
    if (loop_rst || !delay_update_enable)
    begin
      upd_cnt <= 2'h0;
    end
    else if (upd_cnt != 2'(DLC_UPD_HOLD))
    begin
      upd_cnt <= upd_cnt + 2'h1;
    end
  end

  assign upd_ok = delay_update_enable && (upd_cnt == 2'(DLC_UPD_HOLD - 1));

  // Applied setting loads once per qualified request.
  always_ff @(posedge clk)
  begin
    if (loop_rst)
    begin
      applied <= DLC_CODE_RST;
    end
    else if (upd_ok)
    begin
      applied <= delay_control_value;
    end
  end

  always_ff @(posedge clk)
  begin
    if (loop_rst)
    begin
      update_needed_flag <= 1'b0;
    end
    else
    begin
      update_needed_flag <= (delay_control_value != applied);
    end
  end

  always_ff @(posedge clk)
  begin
    if (loop_rst)
    begin
      cascade_out <= '0;
    end
    else
    begin
      cascade_out.code <= to_gray(applied);
      cascade_out.inc <= inc_dir;
    end
  end

  // alignment count
  // Coincident edges count toward lock; any mismatch restarts the count.
  always_ff @(posedge clk)
  begin
    if (loop_rst || (ref_rise != fb_rise))
    begin
      match_cnt <= 3'h0;
    end
    else if (ref_rise && match_cnt != 3'(LOCK_CNT))
    begin
      match_cnt <= match_cnt + 3'h1;
    end
  end

  // Lock state machine.
  always_comb
  begin
    case (state)
      DLC_ST_RESET: next_state = DLC_ST_TRACK;
      DLC_ST_TRACK: next_state = (match_cnt == 3'(LOCK_CNT)) ? DLC_ST_LOCKED : DLC_ST_TRACK;
      DLC_ST_LOCKED: next_state = (match_cnt == 3'(LOCK_CNT)) ? DLC_ST_LOCKED : DLC_ST_TRACK;
      default: next_state = DLC_ST_RESET;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (loop_rst)
    begin
      state <= DLC_ST_RESET;
      lock <= 1'b0;
    end
    else
    begin
      state <= next_state;
      lock <= (next_state == DLC_ST_LOCKED);
    end
  end

  // fine shift
  // Fine shift is a tap on a short register line; resolution is one loop cycle.
  always_ff @(posedge clk)
  begin
    if (loop_rst)
    begin
      primary_clock_out <= 1'b0;
      shift_line <= '0;
      div_cnt <= 2'h0;
    end
    else
    begin
      primary_clock_out <= reference_clock_in;
      shift_line <= {shift_line[4:0], reference_clock_in};
      if (shift_line[cfg.fine_shift[2:0] % 6] && !shift_line[(cfg.fine_shift[2:0] % 6 + 5) % 6])
      begin
        div_cnt <= div_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (loop_rst)
    begin
      secondary_clock_out <= 1'b0;
    end
    else
    begin
      case (cfg.div_sel)
        DLC_DIV_BY2: secondary_clock_out <= div_cnt[0];
        DLC_DIV_BY4: secondary_clock_out <= div_cnt[1];
        default: secondary_clock_out <= shift_line[cfg.fine_shift[2:0] % 6];
      endcase
    end
  end

endmodule // dlc_port

// ### dv/dlc_port_assertions.sv
`timescale 1ns/1ps
module dlc_port_chk #(
  parameter int CODE_W = 6,
  parameter int LOCK_CNT = 4
) (
  input logic clk, // Clock.
  input logic rst, // Reset.
  input logic reference_clock_in, // Reference.
  input logic feedback_clock_in, // Feedback.
  input logic sync_reset_low, // Loop reset.
  input logic arith_freeze, // Freeze.
  input logic delay_update_enable, // Update.
  input dlc_pkg::dlc_cfg_t cfg, // Config.
  input dlc_pkg::dlc_cascade_t cascade_in, // From peer.
  input logic primary_clock_out, // Main clock.
  input logic secondary_clock_out, // Tap clock.
  input logic lock, // Lock.
  input logic update_needed_flag, // Differ.
  input dlc_pkg::dlc_cascade_t cascade_out // To peer.
);
  logic up, ok, r_q, f_q, lone, both;
  logic [2:0] uph;
  logic [3:0] agn;
  // The loop runs only with both resets away; ok also needs three quiet samples behind it.
  assign up = !rst && sync_reset_low;
  assign ok = up && &uph;
  assign both = reference_clock_in && !r_q && feedback_clock_in && !f_q;
  assign lone = (reference_clock_in && !r_q) != (feedback_clock_in && !f_q);
  // Last clock levels and run history.
  always_ff @(posedge clk)
  begin
    r_q <= reference_clock_in;
    f_q <= feedback_clock_in;
    uph <= {uph[1:0], up};
  end
  // Aligned edges since the last lone edge, saturating.
  always_ff @(posedge clk)
  begin
    if (!up || lone) agn <= 4'h0;
    else if (both && agn != 4'hF) agn <= agn + 4'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  lock_reset_low_a: assert property (!up |=> !lock)
    else $error("lock high after loop reset");
  lock_needs_align_a: assert property ($rose(lock) |-> agn >= LOCK_CNT)
    else $error("lock rose too early");
  lone_drops_lock_a: assert property (ok && lone |-> ##[1:2] !lock)
    else $error("lock kept over lone edge");
  primary_copy_a: assert property (ok |-> primary_clock_out == $past(reference_clock_in))
    else $error("primary clock wrong");
  one_update_a: assert property (ok && !cfg.follow_mode && !$past(cfg.follow_mode, 3)
    && $changed(cascade_out.code) |-> $past(delay_update_enable, 2) && $past(delay_update_enable, 3))
    else $error("code moved without update");
  freeze_hold_a: assert property (ok && !cfg.follow_mode && arith_freeze && $past(arith_freeze)
    && !delay_update_enable && !$past(delay_update_enable) |=> $stable(update_needed_flag))
    else $error("frozen flag moved");
  flag_clear_a: assert property (ok && !cfg.follow_mode && arith_freeze && $past(arith_freeze)
    && $past(arith_freeze, 2) && $past(delay_update_enable) && $past(delay_update_enable, 2)
    |=> !update_needed_flag)
    else $error("flag high after update");
  follow_copy_a: assert property (ok && cfg.follow_mode && $past(cfg.follow_mode)
    && $past(cfg.follow_mode, 2) |-> cascade_out.inc == $past(cascade_in.inc, 2))
    else $error("follow increment wrong");
  // The followed code reaches the output only through a qualified update.
  follow_code_a: assert property (ok && $past(cfg.follow_mode, 3) && $changed(cascade_out.code)
    |-> cascade_out.code == $past(cascade_in.code, 3))
    else $error("follow code wrong");
  cover property ($rose(lock));
  cover property (ok && $changed(cascade_out.code));
  cover property (update_needed_flag && arith_freeze);
  cover property ($rose(secondary_clock_out));
endmodule // dlc_port_chk
bind dlc_port dlc_port_chk #(.CODE_W(CODE_W), .LOCK_CNT(LOCK_CNT)) chk (.clk, .rst, .reference_clock_in,
  .feedback_clock_in, .sync_reset_low, .arith_freeze, .delay_update_enable, .cfg, .cascade_in,
  .primary_clock_out, .secondary_clock_out, .lock, .update_needed_flag, .cascade_out);

// ### dv/dlc_fabric_model.sv
`timescale 1ns/1ps
module dlc_fabric_model (
  input logic clk, // Bench clock.
  input logic [1:0] skew, // Feedback lag.
  output logic reference_clock_in, // Reference.
  output logic feedback_clock_in // Feedback.
);
  logic [2:0] ph = 3'h0;
  logic [2:0] fp;
  // Phase steps just after each edge, so the reference period is eight cycles.
  always @(posedge clk)
  begin
    #1;
    ph = ph + 3'h1;
  end
  assign fp = ph - {1'b0, skew};
  assign reference_clock_in = ph[2];
  assign feedback_clock_in = fp[2];
endmodule // dlc_fabric_model

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import dlc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sync_reset_low = 1'b1;
  logic arith_freeze = 1'b0;
  logic delay_update_enable = 1'b0;
  logic [1:0] skew = 2'h0;
  dlc_cfg_t cfg = '0;
  dlc_cascade_t cascade_in = '0;
  dlc_cascade_t cascade_out;
  logic reference_clock_in, feedback_clock_in, primary_clock_out, secondary_clock_out, lock, update_needed_flag;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  // Bench clock, 8 ns period.
  always #4 clk = ~clk;
  dlc_fabric_model FAB (.clk, .skew, .reference_clock_in, .feedback_clock_in);
  dlc_port DUT (.clk, .rst, .reference_clock_in, .feedback_clock_in, .sync_reset_low, .arith_freeze,
    .delay_update_enable, .cfg, .cascade_in, .primary_clock_out, .secondary_clock_out, .lock,
    .update_needed_flag, .cascade_out);
  task automatic finish_test();
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // A hang counts as a mismatch and closes the run.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fails++;
      finish_test();
    end
  end
  task automatic check(input logic [6:0] seen, input logic [6:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Inputs always move 1 ns after the edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_lock();
    int n;
    n = 0;
    while (lock !== 1'b1 && n < 80)
    begin
      cyc(1);
      n++;
    end
    check(lock, 7'h01);
    skew = 2'h2;
    cyc(24);
    check(lock, 7'h00);
  endtask
  task automatic t_update();
    arith_freeze = 1'b1;
    cyc(4);
    check(update_needed_flag, 7'h01);
    delay_update_enable = 1'b1;
    cyc(1);
    delay_update_enable = 1'b0;
    cyc(4);
    check(cascade_out.code, 7'h00);
    delay_update_enable = 1'b1;
    cyc(2);
    delay_update_enable = 1'b0;
    cyc(3);
    check(update_needed_flag, 7'h00);
    check(cascade_out.inc, 7'h01);
    check(cascade_out.code != 6'h00, 7'h01);
    cyc(24);
    check(update_needed_flag, 7'h00);
    arith_freeze = 1'b0;
    cyc(24);
    check(update_needed_flag, 7'h01);
  endtask
  task automatic t_loop_reset();
    skew = 2'h0;
    cyc(60);
    check(lock, 7'h01);
    sync_reset_low = 1'b0;
    cyc(1);
    sync_reset_low = 1'b1;
    cyc(1);
    check({lock, update_needed_flag, cascade_out.code[4:0]}, 7'h00);
  endtask
  // two-cycle update request, then the enable rests for two cycles.
  task automatic upd();
    delay_update_enable = 1'b1;
    cyc(2);
    delay_update_enable = 1'b0;
    cyc(2);
  endtask
  task automatic t_follow();
    cfg.follow_mode = 1'b1;
    cascade_in = {1'b1, 6'h2D};
    cyc(2);
    check(cascade_out.inc, 7'h01);
    check(cascade_out.code, 7'h00);
    upd();
    check(cascade_out, {1'b1, 6'h2D});
    cascade_in = {1'b0, 6'h12};
    cyc(2);
    upd();
    check(cascade_out, {1'b0, 6'h12});
    cfg.follow_mode = 1'b0;
  endtask
  task automatic t_div();
    logic [1:0] sel[3] = '{DLC_DIV_NONE, DLC_DIV_BY2, DLC_DIV_BY4};
    logic prev;
    int n;
    cfg.fine_shift = 6'h03;
    for (int i = 0; i < 3; i++)
    begin
      cfg.div_sel = sel[i];
      cyc(16);
      n = 0;
      repeat (128)
      begin
        prev = secondary_clock_out;
        cyc(1);
        n += int'(secondary_clock_out && !prev);
      end
      check(n >= (16 >> i) - 1 && n <= (16 >> i) + 1, 7'h01);
    end
  endtask
  // Main sequence.
  initial
  begin
    cyc(8);
    rst = 1'b0;
    cyc(2);
    check({lock, cascade_out[5:0]}, 7'h00);
    t_lock();
    t_update();
    t_loop_reset();
    t_follow();
    t_div();
    finish_test();
  end
endmodule // testbench
